/* verilog/rciv_regs.vh */
`ifndef RCIV_REGS_VH
`define RCIV_REGS_VH

////////////////////////////////////////////////////////////////////////
// register byte offsets, one aligned word each
`define RCIV_OFS_STATUS     8'h00
`define RCIV_OFS_POWER_CONTROL_REG       8'h04
`define RCIV_OFS_PC         8'h08
`define RCIV_OFS_PC_HIGH_LATCH     8'h0C
`define RCIV_OFS_IRQ_CONTROL_REG     8'h10
`define RCIV_OFS_PERIPHERAL_IRQ_FLAGS_ONE       8'h14
`define RCIV_OFS_PERIPHERAL_IRQ_FLAGS_TWO       8'h18
`define RCIV_OFS_CAUSE      8'h1C
`define RCIV_OFS_W          8'h20
`define RCIV_OFS_FSR        8'h24
`define RCIV_OFS_TIMER_ZERO_COUNT       8'h28
`define RCIV_OFS_PORTB      8'h2C
`define RCIV_OFS_PORTC      8'h30
`define RCIV_OFS_PORTD      8'h34
`define RCIV_WORD_BYTES     4
`define RCIV_KEEP_NUM       6

////////////////////////////////////////////////////////////////////////
// field positions
`define RCIV_ST_UP_MSB      7
`define RCIV_ST_UP_LSB      5
`define RCIV_ST_TO          4
`define RCIV_ST_PD          3
`define RCIV_ST_LOW_MSB     2
`define RCIV_POWER_CONTROL_REG_POR       1
`define RCIV_POWER_CONTROL_REG_BOR       0
`define RCIV_IC_GIE         7
`define RCIV_IC_FLAG_MSB    2
`define RCIV_IC_EN_MSB      5
`define RCIV_IC_EN_LSB      3

////////////////////////////////////////////////////////////////////////
// reset and load values
`define RCIV_STATUS_POR     8'h18
`define RCIV_UPPER_CLR      3'h0
`define RCIV_LOW_POR        3'h0
`define RCIV_POWER_CONTROL_REG_POR_VAL   2'h1
`define RCIV_PC_RESET       13'h0000
`define RCIV_PC_VECTOR      13'h0004
`define RCIV_PC_STEP        13'h0001
`define RCIV_PC_HIGH_LATCH_RESET   5'h00
`define RCIV_BYTE_POR       8'h00
`define RCIV_IRQ_CONTROL_REG_POR     8'h00
`define RCIV_PIR_POR        8'h00

////////////////////////////////////////////////////////////////////////
// recorded cause codes
`define RCIV_CAUSE_NONE      3'h0
`define RCIV_CAUSE_POR       3'h1
`define RCIV_CAUSE_BOR       3'h2
`define RCIV_CAUSE_EXT_RUN   3'h3
`define RCIV_CAUSE_EXT_SLEEP 3'h4
`define RCIV_CAUSE_WDT_RST   3'h5
`define RCIV_CAUSE_WDT_WAKE  3'h6
`define RCIV_CAUSE_IRQ_WAKE  3'h7

`endif

/* verilog/rciv_keep_reg.v */
`timescale 1ns/10ps
`include "rciv_regs.vh"

module rciv_keep_reg #(
    parameter [7:0] RESET_VAL = `RCIV_BYTE_POR
) (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       ce,
    input  wire       clear,
    input  wire       we,
    input  wire [7:0] wdata,
    output reg  [7:0] q
);

// content is undefined after power-on; zero is as good as any value
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        q <= RESET_VAL;
    end else if (ce) begin
        if (clear) begin
            q <= RESET_VAL;
        end else if (we) begin
            q <= wdata;
        end
    end
end

endmodule // rciv_keep_reg

/* verilog/rciv_ahb_slave.v */
`timescale 1ns/10ps
`include "rciv_regs.vh"

module rciv_ahb_slave (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    output reg  [7:0]  reg_addr,
    output wire        reg_we,
    output wire [7:0]  reg_wdata,
    input  wire [15:0] reg_rdata
);

reg pend;
reg first;
reg wr;
reg addr_ok;

// one wait state on every transfer so that read data is registered
assign hreadyout = ~(pend & first);
assign hresp     = 1'b0;
assign reg_we    = ce & pend & first & wr & addr_ok;
assign reg_wdata = hwdata[7:0];

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        pend     <= 1'b0;
        first    <= 1'b0;
        wr       <= 1'b0;
        addr_ok  <= 1'b0;
        reg_addr <= 8'h00;
        hrdata   <= 32'h00000000;
    end else if (ce) begin
        if (pend & first) begin
            first  <= 1'b0;
            hrdata <= (addr_ok & ~wr) ? {16'h0000, reg_rdata}
                                      : 32'h00000000;
        end else if (hsel & htrans[1] & hready) begin
            pend     <= 1'b1;
            first    <= 1'b1;
            wr       <= hwrite;
            reg_addr <= haddr[7:0];
            addr_ok  <= (haddr[31:8] == 24'h000000);
        end else begin
            pend <= 1'b0;
        end
    end
end

endmodule // rciv_ahb_slave

/* verilog/rciv_core.v */
// Operation
// - power-on sets timeout flag
// - power-on sets sleep-entered flag
// - pin reset in sleep, irq wake: 1/0
// - flag pairs decode watchdog reset/wake, brown-out
// - pin reset running: pc 0, clear top bits
// - resets load pc zero, wakes continue pc+1
// - irq wake with global enable: vector
// - data registers undefined at power-on, else kept
// - power flags cleared by own reset only
// - unimplemented bits read zero
// - flag pair written from the specific event
// - irq wake leaves source flag set
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "rciv_regs.vh"

module rciv_core (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    input  wire        power_on_event,
    input  wire        brownout_event,
    input  wire        external_reset_pin_n,
    input  wire        watchdog_timeout,
    input  wire        sleep_request,
    input  wire [12:0] pc_current,
    input  wire [2:0]  irq_control_set,
    input  wire [7:0]  peripheral_irq_set_one,
    input  wire [7:0]  peripheral_irq_set_two,
    output reg  [12:0] pc_value,
    output reg         pc_load,
    output reg         core_hold,
    output wire        sleeping,
    output reg  [2:0]  reset_cause
);

////////////////////////////////////////////////////////////////////////
localparam [2:0] ST_RUN   = 3'h1;
localparam [2:0] ST_SLEEP = 3'h2;
localparam [2:0] ST_HOLD  = 3'h4;

reg  [2:0]  state;
reg  [7:0]  status;
reg  [1:0]  power_control_reg;
reg  [4:0]  pc_high_latch;
reg  [7:0]  irq_control_reg;
reg  [7:0]  peripheral_irq_flags_one;
reg  [7:0]  peripheral_irq_flags_two;

reg  [2:0]  next_state;
reg  [7:0]  next_status;
reg  [1:0]  next_power_control_reg;
reg  [4:0]  next_pc_high_latch;
reg  [7:0]  next_irq_control_reg;
reg  [7:0]  next_peripheral_irq_flags_one;
reg  [7:0]  next_peripheral_irq_flags_two;
reg  [12:0] next_pc_value;
reg         next_pc_load;
reg         next_core_hold;
reg  [2:0]  next_reset_cause;
reg  [15:0] reg_rdata;

wire [7:0]  reg_addr;
wire        reg_we;
wire [7:0]  reg_wdata;
wire [8*`RCIV_KEEP_NUM-1:0] keep_flat;

wire        st_run;
wire        st_sleep;
wire        st_hold;
wire        ext_low;
wire        irq_pending;
wire        ev_por;
wire        ev_bor;
wire        ev_ext;
wire        ev_wdt;
wire        ev_wake;
wire        any_event;
wire [12:0] pc_next_instr;

////////////////////////////////////////////////////////////////////////
// register bus
rciv_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .reg_addr  (reg_addr),
    .reg_we    (reg_we),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
);

////////////////////////////////////////////////////////////////////////
// event decode, one cause per cycle
assign st_run   = state[0];
assign st_sleep = state[1];
assign st_hold  = state[2];
assign sleeping = st_sleep;
assign ext_low  = ~external_reset_pin_n;

// a set control flag with its enable, or any set peripheral flag, is what ends sleep
assign irq_pending =
    (|(irq_control_reg[`RCIV_IC_FLAG_MSB:0] &
       irq_control_reg[`RCIV_IC_EN_MSB:`RCIV_IC_EN_LSB])) |
    (|peripheral_irq_flags_one) |
    (|peripheral_irq_flags_two);

assign ev_por  = power_on_event;
assign ev_bor  = ~ev_por & brownout_event;
assign ev_ext  = ~ev_por & ~ev_bor & ext_low & ~st_hold;
// pin held low masks the watchdog until it is released
assign ev_wdt  = ~ev_por & ~ev_bor & ~ext_low & watchdog_timeout;
assign ev_wake = ~ev_por & ~ev_bor & ~ext_low & ~watchdog_timeout &
                 st_sleep & irq_pending;
assign any_event = ev_por | ev_bor | ev_ext | ev_wdt | ev_wake;

assign pc_next_instr = pc_current + `RCIV_PC_STEP;

////////////////////////////////////////////////////////////////////////
// next values: software write first, a reset or wake event overrides
always @* begin
    next_state                    = state;
    next_status                   = status;
    next_power_control_reg        = power_control_reg;
    next_pc_high_latch            = pc_high_latch;
    next_irq_control_reg          = irq_control_reg;
    next_peripheral_irq_flags_one = peripheral_irq_flags_one;
    next_peripheral_irq_flags_two = peripheral_irq_flags_two;
    next_pc_value                 = pc_value;
    next_pc_load                  = 1'b0;
    next_core_hold                = 1'b0;
    next_reset_cause              = reset_cause;

    // timeout and sleep-entered are not software writable
    if (reg_we && reg_addr == `RCIV_OFS_STATUS) begin
        next_status[`RCIV_ST_UP_MSB:`RCIV_ST_UP_LSB] =
            reg_wdata[`RCIV_ST_UP_MSB:`RCIV_ST_UP_LSB];
        next_status[`RCIV_ST_LOW_MSB:0] = reg_wdata[`RCIV_ST_LOW_MSB:0];
    end
    if (reg_we && reg_addr == `RCIV_OFS_POWER_CONTROL_REG) begin
        next_power_control_reg = reg_wdata[`RCIV_POWER_CONTROL_REG_POR:`RCIV_POWER_CONTROL_REG_BOR];
    end
    if (reg_we && reg_addr == `RCIV_OFS_PC_HIGH_LATCH) begin
        next_pc_high_latch = reg_wdata[4:0];
    end
    if (reg_we && reg_addr == `RCIV_OFS_IRQ_CONTROL_REG) begin
        next_irq_control_reg = reg_wdata;
    end
    if (reg_we && reg_addr == `RCIV_OFS_PERIPHERAL_IRQ_FLAGS_ONE) begin
        next_peripheral_irq_flags_one = reg_wdata;
    end
    if (reg_we && reg_addr == `RCIV_OFS_PERIPHERAL_IRQ_FLAGS_TWO) begin
        next_peripheral_irq_flags_two = reg_wdata;
    end

    // hardware set beats a software clear in the same cycle
    next_irq_control_reg[`RCIV_IC_FLAG_MSB:0] =
        next_irq_control_reg[`RCIV_IC_FLAG_MSB:0] | irq_control_set;
    next_peripheral_irq_flags_one =
        next_peripheral_irq_flags_one | peripheral_irq_set_one;
    next_peripheral_irq_flags_two =
        next_peripheral_irq_flags_two | peripheral_irq_set_two;

    if (ev_por) begin
        next_status            = `RCIV_STATUS_POR;
        next_status[`RCIV_ST_TO] = 1'b1;
        next_status[`RCIV_ST_PD] = 1'b1;
        next_power_control_reg = `RCIV_POWER_CONTROL_REG_POR_VAL;
        next_pc_high_latch     = `RCIV_PC_HIGH_LATCH_RESET;
        next_irq_control_reg   = `RCIV_IRQ_CONTROL_REG_POR;
        next_peripheral_irq_flags_one = `RCIV_PIR_POR;
        next_peripheral_irq_flags_two = `RCIV_PIR_POR;
        next_pc_value          = `RCIV_PC_RESET;
        next_pc_load           = 1'b1;
        next_core_hold         = 1'b1;
        next_reset_cause       = `RCIV_CAUSE_POR;
        // a pin still low must not overwrite the recorded cause
        next_state             = ext_low ? ST_HOLD : ST_RUN;
    end else if (ev_bor) begin
        next_status[`RCIV_ST_UP_MSB:`RCIV_ST_UP_LSB] = `RCIV_UPPER_CLR;
        next_status[`RCIV_ST_TO] = 1'b1;
        next_status[`RCIV_ST_PD] = 1'b1;
        next_power_control_reg[`RCIV_POWER_CONTROL_REG_BOR] = 1'b0;
        next_pc_high_latch     = `RCIV_PC_HIGH_LATCH_RESET;
        next_pc_value          = `RCIV_PC_RESET;
        next_pc_load           = 1'b1;
        next_core_hold         = 1'b1;
        next_reset_cause       = `RCIV_CAUSE_BOR;
        next_state             = ext_low ? ST_HOLD : ST_RUN;
    end else if (ev_ext) begin
        next_status[`RCIV_ST_UP_MSB:`RCIV_ST_UP_LSB] = `RCIV_UPPER_CLR;
        if (st_sleep) begin
            next_status[`RCIV_ST_TO] = 1'b1;
            next_status[`RCIV_ST_PD] = 1'b0;
            next_reset_cause         = `RCIV_CAUSE_EXT_SLEEP;
        end else begin
            next_reset_cause         = `RCIV_CAUSE_EXT_RUN;
        end
        next_pc_high_latch     = `RCIV_PC_HIGH_LATCH_RESET;
        next_pc_value          = `RCIV_PC_RESET;
        next_pc_load           = 1'b1;
        next_core_hold         = 1'b1;
        next_state             = ST_HOLD;
    end else if (ev_wdt) begin
        next_status[`RCIV_ST_TO] = 1'b0;
        next_pc_load           = 1'b1;
        if (st_sleep) begin
            next_status[`RCIV_ST_PD] = 1'b0;
            next_pc_value      = pc_next_instr;
            next_reset_cause   = `RCIV_CAUSE_WDT_WAKE;
        end else begin
            next_status[`RCIV_ST_UP_MSB:`RCIV_ST_UP_LSB] = `RCIV_UPPER_CLR;
            next_status[`RCIV_ST_PD] = 1'b1;
            next_pc_high_latch = `RCIV_PC_HIGH_LATCH_RESET;
            next_pc_value      = `RCIV_PC_RESET;
            next_core_hold     = 1'b1;
            next_reset_cause   = `RCIV_CAUSE_WDT_RST;
        end
        next_state             = ST_RUN;
    end else if (ev_wake) begin
        next_status[`RCIV_ST_TO] = 1'b1;
        next_status[`RCIV_ST_PD] = 1'b0;
        if (irq_control_reg[`RCIV_IC_GIE]) begin
            next_pc_value      = `RCIV_PC_VECTOR;
        end else begin
            next_pc_value      = pc_next_instr;
        end
        next_pc_load           = 1'b1;
        next_reset_cause       = `RCIV_CAUSE_IRQ_WAKE;
        next_state             = ST_RUN;
    end

    // state moves that are not reset events
    case (state)
        ST_RUN: begin
            if (!any_event && sleep_request) begin
                next_status[`RCIV_ST_TO] = 1'b1;
                next_status[`RCIV_ST_PD] = 1'b0;
                next_state               = ST_SLEEP;
            end
        end
        ST_SLEEP: begin
        end
        ST_HOLD: begin
            if (!ev_por && !ev_bor) begin
                next_core_hold = ext_low;
                if (!ext_low) begin
                    next_state = ST_RUN;
                end
            end
        end
        default: begin
            next_state = ST_RUN;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////
// state registers; async reset acts as the power-on reset
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state                    <= ST_RUN;
        status                   <= `RCIV_STATUS_POR;
        power_control_reg        <= `RCIV_POWER_CONTROL_REG_POR_VAL;
        pc_high_latch            <= `RCIV_PC_HIGH_LATCH_RESET;
        irq_control_reg          <= `RCIV_IRQ_CONTROL_REG_POR;
        peripheral_irq_flags_one <= `RCIV_PIR_POR;
        peripheral_irq_flags_two <= `RCIV_PIR_POR;
        pc_value                 <= `RCIV_PC_RESET;
        pc_load                  <= 1'b0;
        core_hold                <= 1'b1;
        reset_cause              <= `RCIV_CAUSE_POR;
    end else if (ce) begin
        state                    <= next_state;
        status                   <= next_status;
        power_control_reg        <= next_power_control_reg;
        pc_high_latch            <= next_pc_high_latch;
        irq_control_reg          <= next_irq_control_reg;
        peripheral_irq_flags_one <= next_peripheral_irq_flags_one;
        peripheral_irq_flags_two <= next_peripheral_irq_flags_two;
        pc_value                 <= next_pc_value;
        pc_load                  <= next_pc_load;
        core_hold                <= next_core_hold;
        reset_cause              <= next_reset_cause;
    end
end

////////////////////////////////////////////////////////////////////////
// data registers only power-on disturbs
genvar gi;
generate
    for (gi = 0; gi < `RCIV_KEEP_NUM; gi = gi + 1) begin : g_keep
        localparam integer KOFS = `RCIV_OFS_W + `RCIV_WORD_BYTES * gi;
        rciv_keep_reg #(
            .RESET_VAL (`RCIV_BYTE_POR)
        ) u_keep (
            .hclk    (hclk),
            .hresetn (hresetn),
            .ce      (ce),
            .clear   (ev_por),
            .we      (reg_we && (reg_addr == KOFS[7:0])),
            .wdata   (reg_wdata),
            .q       (keep_flat[gi*8 +: 8])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// read mux; narrow registers pad with zero
always @* begin
    reg_rdata = 16'h0000;
    case (reg_addr)
        `RCIV_OFS_STATUS: reg_rdata = {8'h00, status};
        `RCIV_OFS_POWER_CONTROL_REG:   reg_rdata = {14'h0000, power_control_reg};
        `RCIV_OFS_PC:     reg_rdata = {3'h0, pc_value};
        `RCIV_OFS_PC_HIGH_LATCH: reg_rdata = {11'h000, pc_high_latch};
        `RCIV_OFS_IRQ_CONTROL_REG: reg_rdata = {8'h00, irq_control_reg};
        `RCIV_OFS_PERIPHERAL_IRQ_FLAGS_ONE:   reg_rdata = {8'h00, peripheral_irq_flags_one};
        `RCIV_OFS_PERIPHERAL_IRQ_FLAGS_TWO:   reg_rdata = {8'h00, peripheral_irq_flags_two};
        `RCIV_OFS_CAUSE:  reg_rdata = {13'h0000, reset_cause};
        `RCIV_OFS_W:      reg_rdata = {8'h00, keep_flat[7:0]};
        `RCIV_OFS_FSR:    reg_rdata = {8'h00, keep_flat[15:8]};
        `RCIV_OFS_TIMER_ZERO_COUNT:   reg_rdata = {8'h00, keep_flat[23:16]};
        `RCIV_OFS_PORTB:  reg_rdata = {8'h00, keep_flat[31:24]};
        `RCIV_OFS_PORTC:  reg_rdata = {8'h00, keep_flat[39:32]};
        `RCIV_OFS_PORTD:  reg_rdata = {8'h00, keep_flat[47:40]};
        default:          reg_rdata = 16'h0000;
    endcase
end

endmodule // rciv_core

/* testbench/rciv_core_props.sv */
`timescale 1ns/10ps
module rciv_core_props (
    input wire        hclk,
    input wire        hresetn,
    input wire        ce,
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hready,
    input wire        hreadyout,
    input wire        power_on_event,
    input wire        brownout_event,
    input wire        external_reset_pin_n,
    input wire        watchdog_timeout,
    input wire [12:0] pc_current,
    input wire [12:0] pc_value,
    input wire        pc_load,
    input wire        core_hold,
    input wire        sleeping,
    input wire [2:0]  reset_cause
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire quiet = !power_on_event && !brownout_event;
    wire pin_fell_free = quiet && !core_hold && external_reset_pin_n == 1'h0;
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence hold_pulse;
        pc_load && core_hold ##1 !pc_load && !core_hold;
    endsequence
    bus_wait_a: assert property (
        hsel && htrans[1] && hready && ce |=> one_wait)
        else $error("bus wait state wrong");
    por_load_a: assert property (
        power_on_event |=> pc_load && pc_value == 13'h0000 && reset_cause == 3'h1)
        else $error("power-on load wrong");
    bor_load_a: assert property (
        brownout_event && !power_on_event |=> pc_load && reset_cause == 3'h2)
        else $error("brown-out load wrong");
    pin_run_a: assert property (
        pin_fell_free && $past(external_reset_pin_n) && !sleeping
        |=> pc_load && pc_value == 13'h0000 && reset_cause == 3'h3)
        else $error("pin reset in run wrong");
    pin_sleep_a: assert property (
        pin_fell_free && $past(external_reset_pin_n) && sleeping
        |=> pc_load && pc_value == 13'h0000 && reset_cause == 3'h4)
        else $error("pin reset in sleep wrong");
    pin_hold_a: assert property (
        !external_reset_pin_n && !$past(external_reset_pin_n) |-> core_hold)
        else $error("hold dropped while pin low");
    wdt_reset_a: assert property (
        watchdog_timeout && quiet && external_reset_pin_n && !sleeping
        && !core_hold |=> reset_cause == 3'h5 && pc_value == 13'h0000 ##0 hold_pulse)
        else $error("watchdog reset wrong");
    wdt_wake_a: assert property (
        watchdog_timeout && quiet && external_reset_pin_n && sleeping |=> pc_load
        && reset_cause == 3'h6 && pc_value == $past(pc_current) + 13'h0001)
        else $error("watchdog wake wrong");
    irq_wake_a: assert property (
        $rose(pc_load) && reset_cause == 3'h7 |-> pc_value == 13'h0004
        || pc_value == $past(pc_current) + 13'h0001)
        else $error("irq wake target wrong");
endmodule // rciv_core_props

bind rciv_core rciv_core_props u_props (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans),
    .hready(hready), .hreadyout(hreadyout), .power_on_event(power_on_event),
    .brownout_event(brownout_event),
    .external_reset_pin_n(external_reset_pin_n),
    .watchdog_timeout(watchdog_timeout), .pc_current(pc_current),
    .pc_value(pc_value), .pc_load(pc_load), .core_hold(core_hold),
    .sleeping(sleeping), .reset_cause(reset_cause));

/* testbench/tb_rciv_core.sv */
`timescale 1ns/10ps
module tb_rciv_core;
    reg         hclk, hresetn, hsel, hwrite, p_on, b_out, pin_n, wd, slp, seen;
    reg  [31:0] haddr, hwdata, gp, gc;
    reg  [1:0]  htrans;
    reg  [2:0]  ic_set;
    reg  [7:0]  pi_one;
    reg  [12:0] pcc;
    wire        hreadyout, hresp, pc_load, core_hold, sleeping;
    wire [31:0] hrdata;
    wire [12:0] pc_value;
    wire [2:0]  reset_cause;
    integer     error_cnt, n_checks, cyc;
    rciv_core dut (
        .hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .power_on_event(p_on), .brownout_event(b_out),
        .external_reset_pin_n(pin_n), .watchdog_timeout(wd),
        .sleep_request(slp), .pc_current(pcc), .irq_control_set(ic_set),
        .peripheral_irq_set_one(pi_one), .peripheral_irq_set_two(8'h00),
        .pc_value(pc_value), .pc_load(pc_load), .core_hold(core_hold),
        .sleeping(sleeping), .reset_cause(reset_cause));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'h0;
        forever #2 hclk = ~hclk;
    end
    // falling edge: settled, and equal to what the next rising edge sees
    always @(negedge hclk) begin
        if (pc_load === 1'h1) begin
            seen = 1'h1;
            gp = {19'h0, pc_value};
            gc = {29'h0, reset_cause};
        end
    end
    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            error_cnt = error_cnt + 1;
            complete_run;
        end
    end
    task complete_run;
        begin
            if (error_cnt == 0 && n_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("BAD %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task wait_rdy(output [31:0] q);
        reg r;
        begin
            r = 1'h0;
            while (r !== 1'h1) begin
                @(negedge hclk);
                r = hreadyout;
                q = hrdata;
                @(posedge hclk);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        begin
            @(posedge hclk);
            hsel <= 1'h1;
            htrans <= 2'h2;
            haddr <= {24'h000000, a};
            hwrite <= w;
            wait_rdy(q);
            htrans <= 2'h0;
            hsel <= 1'h0;
            hwdata <= d;
            wait_rdy(q);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        reg [31:0] q;
        bus(1'h1, a, d, q);
    endtask
    task rd(input [7:0] a, input [31:0] e);
        reg [31:0] q;
        begin
            bus(1'h0, a, 32'h0, q);
            chk(q, e);
        end
    endtask
    // m = {power-on, brown-out, watchdog, sleep, pin}; pin held 3 cycles
    task ev(input [4:0] m);
        begin
            seen = 1'h0;
            @(posedge hclk);
            {p_on, b_out, wd, slp} <= m[4:1];
            pin_n <= !m[0];
            @(posedge hclk);
            {p_on, b_out, wd, slp} <= 4'h0;
            if (m[0])
                repeat (2) @(posedge hclk);
            pin_n <= 1'h1;
        end
    endtask
    task chk_load(input [31:0] p, input [31:0] c);
        begin
            repeat (20) if (!seen) @(negedge hclk);
            chk({31'h0, seen}, 32'h1);
            chk(gp, p);
            chk(gc, c);
        end
    endtask
    task data_regs(input w, input keep);
        reg [7:0] i;
        for (i = 8'h00; i < 8'h06; i = i + 8'h01)
            if (w)
                wr(8'h20 + {i[5:0], 2'h0}, {24'h0, 8'hA0 + i});
            else
                rd(8'h20 + {i[5:0], 2'h0}, keep ? {24'h0, 8'hA0 + i} : 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_por;
        begin
            rd(8'h00, 32'h18);
            rd(8'h04, 32'h01);
            rd(8'h1C, 32'h01);
            data_regs(1'h0, 1'h0);
            wr(8'h3C, 32'hFF);
            rd(8'h3C, 32'h0);
        end
    endtask
    task t_pin_run;
        begin
            wr(8'h00, 32'hE7);
            rd(8'h00, 32'hFF);
            wr(8'h04, 32'h03);
            data_regs(1'h1, 1'h1);
            ev(5'h01);
            chk_load(32'h0, 32'h3);
            rd(8'h00, 32'h1F);
            rd(8'h04, 32'h03);
            data_regs(1'h0, 1'h1);
        end
    endtask
    task t_wdt;
        begin
            ev(5'h04);
            chk_load(32'h0, 32'h5);
            rd(8'h00, 32'h0F);
            rd(8'h04, 32'h03);
        end
    endtask
    task t_pin_sleep;
        begin
            wr(8'h00, 32'hE7);
            ev(5'h02);
            rd(8'h00, 32'hF7);
            ev(5'h01);
            chk_load(32'h0, 32'h4);
            rd(8'h00, 32'h17);
        end
    endtask
    task t_wdt_wake;
        begin
            wr(8'h00, 32'hE7);
            ev(5'h02);
            ev(5'h04);
            chk_load({19'h0, pcc} + 32'h1, 32'h6);
            rd(8'h00, 32'hE7);
            chk({31'h0, sleeping}, 32'h0);
            data_regs(1'h0, 1'h1);
        end
    endtask
    task t_irq_wake;
        integer i;
        for (i = 0; i < 3; i = i + 1) begin
            wr(8'h10, (i == 1) ? 32'h88 : 32'h08);
            ev(5'h02);
            repeat (3) @(posedge hclk);
            seen = 1'h0;
            ic_set <= (i < 2) ? 3'h1 : 3'h0;
            pi_one <= (i == 2) ? 8'h01 : 8'h00;
            @(posedge hclk);
            ic_set <= 3'h0;
            pi_one <= 8'h00;
            chk_load((i == 1) ? 32'h4 : {19'h0, pcc} + 32'h1, 32'h7);
            rd(8'h00, 32'hF7);
            rd(8'h10, (i == 1) ? 32'h89 : (i == 0) ? 32'h09 : 32'h08);
            rd(8'h14, (i == 2) ? 32'h01 : 32'h00);
            wr(8'h10, 32'h0);
            wr(8'h14, 32'h0);
        end
    endtask
    task t_bor_prio;
        begin
            ev(5'h0D);
            chk_load(32'h0, 32'h2);
            rd(8'h04, 32'h02);
            rd(8'h00, 32'h1F);
            ev(5'h05);
            chk_load(32'h0, 32'h3);
            ev(5'h1C);
            chk_load(32'h0, 32'h1);
            rd(8'h00, 32'h18);
            rd(8'h04, 32'h01);
            data_regs(1'h0, 1'h0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {hresetn, hsel, hwrite, p_on, b_out, wd, slp, seen} = 8'h00;
        {haddr, hwdata, htrans, ic_set, pi_one} = 77'h0;
        pin_n = 1'h1;
        pcc = 13'h0123;
        {error_cnt, n_checks, cyc} = {32'h0, 32'h0, 32'h0};
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        t_por;
        t_pin_run;
        t_wdt;
        t_pin_sleep;
        t_wdt_wake;
        t_irq_wake;
        t_bor_prio;
        complete_run;
    end
endmodule // tb_rciv_core
